// ===== verilog/tfs_pkg.sv
// Purpose: Shared constants and types for the timer flag skip block
// Assumes: 40 MHz instruction clock, APB register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
package tfs_pkg;

	// Register byte offsets
	localparam logic [7:0] TFS_OFF_ICTL1    = 8'h00;
	localparam logic [7:0] TFS_OFF_ICTL2    = 8'h04;
	localparam logic [7:0] TFS_OFF_FLAGS    = 8'h08;
	localparam logic [7:0] TFS_OFF_IRQ_STS  = 8'h0c;
	localparam logic [7:0] TFS_OFF_IRQ_CLR  = 8'h10;
	localparam logic [7:0] TFS_OFF_IRQ_EN   = 8'h14;

	// Field positions
	localparam int unsigned TFS_T2_EN_BIT   = 3;
	localparam int unsigned TFS_T3_EN_BIT   = 0;
	localparam int unsigned TFS_CTL_W       = 4;
	localparam int unsigned TFS_NUM_TMR     = 2;
	localparam int unsigned TFS_FLG_PEND    = 2;

	// Reset values
	localparam logic [3:0] TFS_ICTL_RST     = 4'h0;
	localparam logic [1:0] TFS_STS_RST      = 2'h0;
	localparam logic [1:0] TFS_IRQ_EN_RST   = 2'h0;

	// Instruction kinds presented by the sequencer
	typedef enum logic [1:0] {
		TFS_OTHER   = 2'b00,
		TFS_TEST_T2 = 2'b01,
		TFS_TEST_T3 = 2'b10
	} tfs_instr_e;

	// Register decode results
	typedef enum logic [2:0] {
		TFS_R_ICTL1  = 3'b000,
		TFS_R_ICTL2  = 3'b001,
		TFS_R_FLAGS  = 3'b010,
		TFS_R_STS    = 3'b011,
		TFS_R_CLR    = 3'b100,
		TFS_R_EN     = 3'b101,
		TFS_R_NONE   = 3'b111
	} tfs_reg_e;

endpackage : tfs_pkg

// ===== verilog/tfs_flag_if.sv
// Purpose: Carrier between the controller and one timer flag unit
// Assumes: Single clock domain
// Notes:   One instance per timer request flag
`timescale 1ns/100ps
interface tfs_flag_if;
	logic set;    // Timer request event
	logic test;   // Test instruction for this timer executes
	logic en;     // Interrupt enable bit of this timer
	logic flag;   // Request flag state
	logic skip;   // Test instruction skips

	modport unit (input set, input test, input en, output flag, output skip);
	modport ctrl (output set, output test, output en, input flag, input skip);
endinterface : tfs_flag_if

// ===== verilog/tfs_flag_unit.sv
// Purpose: One timer request flag with its skip-test evaluation
// Assumes: Test strobe is one cycle per executed test instruction
// Notes:   A timer event in the same cycle as a skip keeps the flag set
`timescale 1ns/100ps
module tfs_flag_unit (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// Controller side
	tfs_flag_if.unit  fif
);
	import tfs_pkg::*;

	logic flag_r;

	// Skip only when enable clear and flag set; enable set makes it a no-op
	assign fif.skip = fif.test & ~fif.en & flag_r;
	assign fif.flag = flag_r;

	// Flag: set wins over the skip clear so no request is lost
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			flag_r <= 1'b0;
		end else if (fif.set) begin
			flag_r <= 1'b1;
		end else if (fif.skip) begin
			flag_r <= 1'b0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	property p_skip_when_set;
		fif.test && !fif.en && flag_r |-> fif.skip;
	endproperty
	a_skip_when_set: assert property (p_skip_when_set) else $error("flag set, no skip");

	property p_skip_clears;
		fif.skip && !fif.set |=> !fif.flag;
	endproperty
	a_skip_clears: assert property (p_skip_clears) else $error("flag kept after skip");

	property p_nop_keeps;
		fif.test && fif.en && !fif.set |-> !fif.skip ##1 fif.flag == $past(flag_r);
	endproperty
	a_nop_keeps: assert property (p_nop_keeps) else $error("no-op altered flag");

	property p_set_wins;
		fif.set |=> fif.flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("timer event lost");

endmodule : tfs_flag_unit

// ===== verilog/tfs_top.sv
// Purpose: Execution of the timer 2 and timer 3 request skip instructions
// Assumes: One instruction per valid cycle; timers pulse their request set
// Notes:   APB slave with zero wait states; skipped word is fetched, not run
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
module tfs_top (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_nrst,
	// APB slave
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [7:0]           i_paddr,
	input  wire logic [31:0]          i_pwdata,
	output logic      [31:0]          o_prdata,
	output logic                      o_pready,
	output logic                      o_pslverr,
	// Timer request events
	input  wire logic [1:0]           i_timer_req_set,
	// Instruction sequencer
	input  wire logic                 i_instr_valid,
	input  wire tfs_pkg::tfs_instr_e  i_instr_kind,
	output logic                      o_exec_en,
	output logic                      o_skip_next,
	// Status and interrupt
	output logic      [1:0]           o_req_flags,
	output logic                      o_irq
);
	import tfs_pkg::*;

	// Register decode, shared by read and write paths
	function automatic tfs_reg_e decode(input logic [7:0] addr);
		unique case (addr)
			TFS_OFF_ICTL1:   decode = TFS_R_ICTL1;
			TFS_OFF_ICTL2:   decode = TFS_R_ICTL2;
			TFS_OFF_FLAGS:   decode = TFS_R_FLAGS;
			TFS_OFF_IRQ_STS: decode = TFS_R_STS;
			TFS_OFF_IRQ_CLR: decode = TFS_R_CLR;
			TFS_OFF_IRQ_EN:  decode = TFS_R_EN;
			default:         decode = TFS_R_NONE;
		endcase
	endfunction : decode

	logic [TFS_CTL_W-1:0]   ictl1_r;
	logic [TFS_CTL_W-1:0]   ictl2_r;
	logic [1:0]             sts_r;
	logic [1:0]             irq_en_r;
	logic                   skip_pend_r;
	logic [31:0]            prdata_r;
	logic                   setup;
	logic                   access;
	logic                   wr_acc;
	tfs_reg_e               acc_reg;
	tfs_reg_e               setup_reg;
	logic [1:0]             test_vec;
	logic [1:0]             en_vec;
	logic [1:0]             skip_vec;
	logic [1:0]             flag_vec;
	logic                   any_skip;

	tfs_flag_if fif [TFS_NUM_TMR] ();

	// APB phases; a transfer completes at the access edge, never waited
	assign setup     = i_psel & ~i_penable;
	assign access    = i_psel & i_penable;
	assign wr_acc    = access & i_pwrite;
	assign acc_reg   = decode(i_paddr);
	assign setup_reg = decode(i_paddr);
	assign o_pready  = 1'b1;
	assign o_pslverr = access & (acc_reg == TFS_R_NONE);
	assign o_prdata  = prdata_r;

	// Enable bits for the skip/no-op choice
	assign en_vec[0] = ictl1_r[TFS_T2_EN_BIT];
	assign en_vec[1] = ictl2_r[TFS_T3_EN_BIT];

	// Sequencer gating: the word after a skip is fetched but not run
	assign o_exec_en   = i_instr_valid & ~skip_pend_r;
	assign o_skip_next = skip_pend_r;
	assign test_vec[0] = o_exec_en & (i_instr_kind == TFS_TEST_T2);
	assign test_vec[1] = o_exec_en & (i_instr_kind == TFS_TEST_T3);
	assign any_skip    = |skip_vec;

	// One flag unit per timer
	genvar gi;
	generate
		for (gi = 0; gi < TFS_NUM_TMR; gi++) begin : g_flag
			assign fif[gi].set  = i_timer_req_set[gi];
			assign fif[gi].test = test_vec[gi];
			assign fif[gi].en   = en_vec[gi];
			assign skip_vec[gi] = fif[gi].skip;
			assign flag_vec[gi] = fif[gi].flag;

			tfs_flag_unit u_flag (
				.i_clk  (i_clk),
				.i_nrst (i_nrst),
				.fif    (fif[gi])
			);
		end
	endgenerate

	assign o_req_flags = flag_vec;

	// Skip pending: armed by a skip, consumed by the next instruction slot
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			skip_pend_r <= 1'b0;
		end else if (any_skip) begin
			skip_pend_r <= 1'b1;
		end else if (i_instr_valid) begin
			skip_pend_r <= 1'b0;
		end
	end

	// Interrupt control registers, written only by software
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			ictl1_r <= TFS_ICTL_RST;
			ictl2_r <= TFS_ICTL_RST;
		end else if (wr_acc) begin
			if (acc_reg == TFS_R_ICTL1) begin
				ictl1_r <= i_pwdata[TFS_CTL_W-1:0];
			end
			if (acc_reg == TFS_R_ICTL2) begin
				ictl2_r <= i_pwdata[TFS_CTL_W-1:0];
			end
		end
	end

	// Interrupt enable register
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			irq_en_r <= TFS_IRQ_EN_RST;
		end else if (wr_acc && acc_reg == TFS_R_EN) begin
			irq_en_r <= i_pwdata[1:0];
		end
	end

	// Sticky skip events; write-one clears, a new skip beats the clear
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			sts_r <= TFS_STS_RST;
		end else begin
			for (int i = 0; i < TFS_NUM_TMR; i++) begin
				if (skip_vec[i]) begin
					sts_r[i] <= 1'b1;
				end else if (wr_acc && acc_reg == TFS_R_CLR && i_pwdata[i]) begin
					sts_r[i] <= 1'b0;
				end
			end
		end
	end

	// Level interrupt while any enabled event bit stands
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(sts_r & irq_en_r);
		end
	end

	// Read data captured in setup so it is stable through access
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup && !i_pwrite) begin
			prdata_r <= 32'h0000_0000;
			unique case (setup_reg)
				TFS_R_ICTL1: prdata_r[TFS_CTL_W-1:0] <= ictl1_r;
				TFS_R_ICTL2: prdata_r[TFS_CTL_W-1:0] <= ictl2_r;
				TFS_R_FLAGS: prdata_r[TFS_FLG_PEND:0] <= {skip_pend_r, flag_vec};
				TFS_R_STS:   prdata_r[1:0] <= sts_r;
				TFS_R_EN:    prdata_r[1:0] <= irq_en_r;
				TFS_R_CLR:   prdata_r <= 32'h0000_0000;
				TFS_R_NONE:  prdata_r <= 32'h0000_0000;
				default:     prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_t2_skip;
		o_exec_en && i_instr_kind == TFS_TEST_T2 && !ictl1_r[TFS_T2_EN_BIT] && flag_vec[0];
	endsequence

	sequence s_t3_skip;
		o_exec_en && i_instr_kind == TFS_TEST_T3 && !ictl2_r[TFS_T3_EN_BIT] && flag_vec[1];
	endsequence

	// Next slot withheld; p_pend_held keeps it withheld until a word arrives
	sequence s_next_suppressed;
		skip_pend_r && !o_exec_en;
	endsequence

	property p_t2_skip;
		s_t2_skip |=> s_next_suppressed;
	endproperty
	a_t2_skip: assert property (p_t2_skip) else $error("timer 2 skip not applied");

	property p_t2_clear;
		s_t2_skip ##0 !i_timer_req_set[0] |=> !o_req_flags[0];
	endproperty
	a_t2_clear: assert property (p_t2_clear) else $error("timer 2 flag not cleared");

	property p_t2_nop;
		o_exec_en && i_instr_kind == TFS_TEST_T2 && ictl1_r[TFS_T2_EN_BIT] && !skip_vec[1]
			|=> !skip_pend_r
			&& o_req_flags[0] == ($past(flag_vec[0]) | $past(i_timer_req_set[0]));
	endproperty
	a_t2_nop: assert property (p_t2_nop) else $error("timer 2 no-op misbehaved");

	property p_t2_en_bit;
		wr_acc && acc_reg == TFS_R_ICTL1 |=> en_vec[0] == $past(i_pwdata[3]);
	endproperty
	a_t2_en_bit: assert property (p_t2_en_bit) else $error("timer 2 enable bit wrong");

	property p_t3_skip;
		s_t3_skip |=> s_next_suppressed;
	endproperty
	a_t3_skip: assert property (p_t3_skip) else $error("timer 3 skip not applied");

	property p_t3_clear;
		s_t3_skip ##0 !i_timer_req_set[1] |=> !o_req_flags[1];
	endproperty
	a_t3_clear: assert property (p_t3_clear) else $error("timer 3 flag not cleared");

	property p_t3_nop;
		o_exec_en && i_instr_kind == TFS_TEST_T3 && ictl2_r[TFS_T3_EN_BIT] && !skip_vec[0]
			|=> !skip_pend_r
			&& o_req_flags[1] == ($past(flag_vec[1]) | $past(i_timer_req_set[1]));
	endproperty
	a_t3_nop: assert property (p_t3_nop) else $error("timer 3 no-op misbehaved");

	property p_t3_en_bit;
		wr_acc && acc_reg == TFS_R_ICTL2 |=> en_vec[1] == $past(i_pwdata[0]);
	endproperty
	a_t3_en_bit: assert property (p_t3_en_bit) else $error("timer 3 enable bit wrong");

	property p_one_slot;
		skip_pend_r && i_instr_valid && !any_skip |=> !skip_pend_r;
	endproperty
	a_one_slot: assert property (p_one_slot) else $error("skip covered more than one word");

	property p_sticky;
		skip_vec[0] |=> sts_r[0] ##1 (o_irq == $past(irq_en_r[0]) || $past(sts_r[1] && irq_en_r[1]));
	endproperty
	a_sticky: assert property (p_sticky) else $error("skip event not latched");

	// Skip window survives idle cycles and blocks any test inside it
	property p_pend_held;
		skip_pend_r && !i_instr_valid |=> skip_pend_r;
	endproperty
	a_pend_held: assert property (p_pend_held) else $error("skip window dropped early");

	property p_no_test;
		skip_pend_r |-> !test_vec[0] && !test_vec[1];
	endproperty
	a_no_test: assert property (p_no_test) else $error("test ran in skipped slot");

	// A request flag falls only through a skip, never through a no-op
	property p_t2_kept;
		o_req_flags[0] && !skip_vec[0] |=> o_req_flags[0];
	endproperty
	a_t2_kept: assert property (p_t2_kept) else $error("timer 2 flag lost");

	property p_t3_kept;
		o_req_flags[1] && !skip_vec[1] |=> o_req_flags[1];
	endproperty
	a_t3_kept: assert property (p_t3_kept) else $error("timer 3 flag lost");

	// Interrupt is a registered copy of the enabled status
	property p_irq_lvl;
		1'b1 |=> o_irq == $past(|(sts_r & irq_en_r));
	endproperty
	a_irq_lvl: assert property (p_irq_lvl) else $error("interrupt level wrong");

	property p_sts_clr;
		wr_acc && acc_reg == TFS_R_CLR && i_pwdata[0] && !skip_vec[0] |=> !sts_r[0];
	endproperty
	a_sts_clr: assert property (p_sts_clr) else $error("status bit not cleared");

	// Read path returns the control bits software wrote
	property p_rd_ictl1;
		setup && !i_pwrite && setup_reg == TFS_R_ICTL1
			|=> o_prdata == {28'h0000000, $past(ictl1_r)};
	endproperty
	a_rd_ictl1: assert property (p_rd_ictl1) else $error("control one read wrong");

	property p_rd_ictl2;
		setup && !i_pwrite && setup_reg == TFS_R_ICTL2
			|=> o_prdata == {28'h0000000, $past(ictl2_r)};
	endproperty
	a_rd_ictl2: assert property (p_rd_ictl2) else $error("control two read wrong");

	// Unmapped writes must not disturb any register
	property p_bad_wr;
		wr_acc && acc_reg == TFS_R_NONE
			|=> $stable(ictl1_r) && $stable(ictl2_r) && $stable(irq_en_r);
	endproperty
	a_bad_wr: assert property (p_bad_wr) else $error("unmapped write took effect");

endmodule : tfs_top

// ===== tb/tfs_top_bench.sv
// Purpose: Self-checking bench for the timer flag skip block
// Assumes: Zero wait APB slave, one instruction slot per cycle
// Notes:   Scenario order matters, flags left set are cleared later
`timescale 1ns/100ps
module tfs_top_bench;
	import tfs_pkg::*;
	logic        i_clk, i_nrst, psel, penable, pwrite, valid, irq, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  req_set, flags;
	tfs_instr_e  kind;
	logic        exec_en, skip_next, err;
	int          n_mismatch = 0;
	int          checks     = 0;
	int          cyc        = 0;

	tfs_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_timer_req_set(req_set),
		.i_instr_valid(valid), .i_instr_kind(kind), .o_exec_en(exec_en),
		.o_skip_next(skip_next), .o_req_flags(flags), .o_irq(irq));

	// 25 ns period clock
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	// Hang guard, far above the hundred or so cycles needed
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask : chk

	// One APB transfer; waits on pready, bounded only by the hang guard
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Optionally raise a flag, run one test, then one following slot
	task automatic try_test(input tfs_instr_e k, input int fb, input logic pend,
		input logic exp_skip);
		if (pend) begin
			@(posedge i_clk);
			req_set <= 2'b01 << fb;
			@(posedge i_clk);
			req_set <= 2'b00;
		end
		@(posedge i_clk);
		valid <= 1'b1;
		kind  <= k;
		@(posedge i_clk);
		kind  <= TFS_OTHER;
		#1;
		chk("skip_next", exp_skip, skip_next);
		chk("req_flag", pend & !exp_skip, flags[fb]);
		chk("exec_en", !exp_skip, exec_en);
		@(posedge i_clk);
		valid <= 1'b0;
		#1;
		chk("skip_end", 1'b0, skip_next);
	endtask : try_test

	task automatic t2_tests();
		apb(1'b1, TFS_OFF_ICTL1, 32'h0000_0007);
		try_test(TFS_TEST_T2, 0, 1'b1, 1'b1);
		try_test(TFS_TEST_T2, 0, 1'b0, 1'b0);
		apb(1'b1, TFS_OFF_ICTL1, 32'h0000_0008);
		try_test(TFS_TEST_T2, 0, 1'b1, 1'b0);
		apb(1'b1, TFS_OFF_ICTL1, 32'h0000_0000);
		try_test(TFS_TEST_T2, 0, 1'b1, 1'b1);
		$display("test t2_tests done");
	endtask : t2_tests

	task automatic t3_tests();
		apb(1'b1, TFS_OFF_ICTL2, 32'h0000_000e);
		try_test(TFS_TEST_T3, 1, 1'b1, 1'b1);
		try_test(TFS_TEST_T3, 1, 1'b0, 1'b0);
		apb(1'b1, TFS_OFF_ICTL2, 32'h0000_0001);
		try_test(TFS_TEST_T3, 1, 1'b1, 1'b0);
		apb(1'b1, TFS_OFF_ICTL2, 32'h0000_0000);
		try_test(TFS_TEST_T3, 1, 1'b1, 1'b1);
		$display("test t3_tests done");
	endtask : t3_tests

	// Timer event in the skip cycle, idle gap, then a test in the skipped slot
	task automatic edge_tests();
		@(posedge i_clk);
		req_set <= 2'b01;
		@(posedge i_clk);
		valid   <= 1'b1;
		kind    <= TFS_TEST_T2;
		@(posedge i_clk);
		req_set <= 2'b00;
		valid   <= 1'b0;
		#1;
		chk("set_wins", 1'b1, flags[0]);
		@(posedge i_clk);
		valid   <= 1'b1;
		#1;
		chk("skip_held", 1'b1, skip_next);
		chk("supp_exec", 1'b0, exec_en);
		@(posedge i_clk);
		valid   <= 1'b0;
		kind    <= TFS_OTHER;
		#1;
		chk("supp_flag", 1'b1, flags[0]);
		chk("supp_skip", 1'b0, skip_next);
		try_test(TFS_TEST_T2, 0, 1'b0, 1'b1);
		$display("test edge_tests done");
	endtask : edge_tests

	// Sticky status, enable, clear and a bad address
	task automatic irq_tests();
		apb(1'b0, TFS_OFF_ICTL1, 32'h0);
		chk("ictl1", 32'h0, rd);
		apb(1'b0, TFS_OFF_IRQ_STS, 32'h0);
		chk("irq_sts", 32'h3, rd);
		chk("irq_off", 1'b0, irq);
		apb(1'b1, TFS_OFF_IRQ_EN, 32'h0000_0001);
		repeat (2) @(posedge i_clk);
		#1;
		chk("irq_on", 1'b1, irq);
		apb(1'b1, TFS_OFF_IRQ_CLR, 32'h0000_0003);
		apb(1'b0, TFS_OFF_IRQ_STS, 32'h0);
		chk("irq_sts_clr", 32'h0, rd);
		chk("irq_clr", 1'b0, irq);
		apb(1'b0, 8'h40, 32'h0);
		chk("pslverr", 1'b1, err);
		apb(1'b1, 8'h40, 32'h0000_000f);
		chk("pslverr_wr", 1'b1, err);
		apb(1'b0, TFS_OFF_ICTL2, 32'h0);
		chk("ictl2", 32'h0, rd);
		apb(1'b0, TFS_OFF_FLAGS, 32'h0);
		chk("flags_reg", 32'h0, rd);
		$display("test irq_tests done");
	endtask : irq_tests

	initial begin
		i_nrst  = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		req_set = 2'b00;
		valid   = 1'b0;
		kind    = TFS_OTHER;
		repeat (12) @(posedge i_clk);
		i_nrst <= 1'b1;
		#1;
		chk("flags_rst", 2'b00, flags);
		t2_tests();
		t3_tests();
		edge_tests();
		irq_tests();
		wrap_up();
	end
endmodule : tfs_top_bench
